/* bench/tppo_enc_model.sv */
`timescale 1ns/100ps
`default_nettype none
module tppo_enc_model (
  input wire logic clk, // Step timing.
  output logic enc_a, // Phase A.
  output logic enc_b // Phase B.
);
  int gap = 4;
  initial begin
    enc_a = 1'b0;
    enc_b = 1'b0;
  end
  // One step moves one phase only, so the pair stays a quarter period apart.
  task automatic step(input logic fwd);
    repeat (gap) @(posedge clk);
    if ((enc_a == enc_b) == fwd) begin
      enc_a <= ~enc_a;
    end else begin
      enc_b <= ~enc_b;
    end
  endtask
endmodule
`default_nettype wire

/* bench/tppo_properties.sv */
`timescale 1ns/100ps
`default_nettype none
module tppo_properties
  import tppo_pkg::*;
(
  input wire logic hclk, // Clock.
  input wire logic hresetn, // Reset.
  input wire logic hsel, // Select.
  input wire logic [31:0] haddr, // Address.
  input wire logic [1:0] htrans, // Type.
  input wire logic hwrite, // Write.
  input wire logic hready, // Ready.
  input wire logic hreadyout, // Ready out.
  input wire logic hresp, // Response.
  input wire logic [31:0] hrdata, // Read data.
  input wire logic [4:0] wave_out, // Waves.
  input wire logic [15:0] pattern_out, // Pattern.
  input wire logic dma_req, // Request.
  input wire logic irq // Interrupt.
);
  logic wr_seen_r;
  logic wr_seen_nxt;
  logic take;
  assign take = hsel && hready && htrans == TPPO_HTRANS_NONSEQ;
  always_comb begin
    wr_seen_nxt = wr_seen_r || (take && hwrite);
  end
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_seen_r <= 1'b0;
    end else begin
      wr_seen_r <= wr_seen_nxt;
    end
  end
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  reset_clear_a: assert property ($rose(hresetn) |-> pattern_out == 16'h0000 && !dma_req)
    else $error("Pattern not clear after reset.");
  idle_quiet_a: assert property (!wr_seen_r |-> pattern_out == 16'h0000 && !dma_req && !irq)
    else $error("Activity before configuration.");
  idle_wave_a: assert property (!wr_seen_r |-> wave_out == 5'h00)
    else $error("Wave before configuration.");
  set_dma_a: assert property ((pattern_out & ~$past(pattern_out)) != 16'h0000 |-> dma_req)
    else $error("Update without request.");
  pout_read_a: assert property (take && !hwrite && haddr == 32'h1C |=>
    hrdata == {16'h0000, $past(pattern_out)}) else $error("Pattern readback wrong.");
  unmapped_zero_a: assert property (take && !hwrite && haddr == 32'hFC |=> hrdata == 32'h0)
    else $error("Unmapped read not zero.");
  zero_wait_a: assert property (hreadyout && !hresp)
    else $error("Wait or error response.");
  irq_clear_a: assert property ($fell(irq) |-> $past(take) || $past(take, 2))
    else $error("Interrupt dropped without access.");
endmodule
bind tppo_top tppo_properties u_props (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite,
  .hready, .hreadyout, .hresp, .hrdata, .wave_out, .pattern_out, .dma_req, .irq);
`default_nettype wire

/* bench/tppo_top_test.sv */
`timescale 1ns/100ps
`default_nettype none
module tppo_top_test
  import tppo_pkg::*;
;
  logic hclk, hresetn, hsel, hwrite, eb;
  logic [1:0] htrans;
  logic [31:0] haddr, hwdata, rdv;
  logic [15:0] pm, d, m, mid;
  wire logic hready, hreadyout, hresp, dma_req, irq, enc_a, enc_b;
  wire logic [31:0] hrdata;
  wire logic [4:0] wave_out;
  wire logic [15:0] pattern_out;
  int errors, check_count, c, hi;
  int cyc = 0;
  logic [31:0] ra [8] = '{32'h00, 32'h0C, 32'h1C, 32'h14, 32'h24, 32'h64, 32'hFC, 32'hA4};
  logic [31:0] re [8] = '{32'h0, 32'h0, 32'h0, 32'h0, 32'hFFFF, 32'hFFFF, 32'h0, 32'h0};
  assign hready = hreadyout;
  tppo_top u_dut (.hclk, .hresetn, .ce(1'b1), .hsel, .haddr, .htrans, .hwrite,
    .hsize(3'b010), .hwdata, .hready, .hreadyout, .hresp, .hrdata, .enc_a, .enc_b,
    .wave_out, .pattern_out, .dma_req, .irq);
  tppo_enc_model u_enc (.clk(hclk), .enc_a, .enc_b);
  initial begin
    hclk = 1'b0;
    forever #5 hclk = ~hclk;
  end
  always @(posedge hclk) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      errors = errors + 1;
      tally_and_finish();
    end
  end
  function automatic logic [31:0] cha(input int n, input logic [3:0] s);
    return 32'(TPPO_OFS_CH0) + 32'(TPPO_CH_STRIDE) * n + 32'(s);
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic rdy();
    do begin
      @(posedge hclk);
    end while (hready !== 1'b1);
  endtask
  task automatic xfer(input logic w, input logic [31:0] a, input logic [31:0] wd);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= w;
    htrans <= TPPO_HTRANS_NONSEQ;
    rdy();
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= wd;
    rdy();
    rdv = hrdata;
  endtask
  task automatic wait_chg(input logic [15:0] old);
    int n;
    n = 0;
    while (pattern_out === old && n < 300) begin
      @(posedge hclk);
      n++;
    end
  endtask
  task automatic tally_and_finish();
    if (errors == 0 && check_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  initial begin
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'b00;
    hwrite = 1'b0;
    hwdata = 32'h0;
    errors = 0;
    check_count = 0;
    pm = 16'h0000;
    rdv = $urandom(10090);
    repeat (6) @(posedge hclk);
    hresetn <= 1'b1;
    foreach (ra[i]) begin
      xfer(1'b0, ra[i], 32'h0);
      chk(rdv, re[i]);
    end
    for (int i = 0; i < 5; i++) xfer(1'b1, cha(i, TPPO_SUB_PERIOD), 4 + $urandom % 12);
    xfer(1'b1, 32'h00, 32'h1F);
    for (int g = 0; g < 4; g++) begin
      d = 16'($urandom);
      m = 16'($urandom);
      xfer(1'b1, 32'h04, {16'h0, d});
      xfer(1'b1, 32'h08, {16'h0, m});
      xfer(1'b1, 32'h0C, (32'hFFF & ~(32'h7 << 3 * g)) | (g << 3 * g));
      xfer(1'b1, 32'h18, (g > 0) ? 32'h1E0 : 32'h0);
      xfer(1'b1, 32'h10, 32'h1 << g);
      c = 0;
      while (dma_req !== 1'b1 && c < 100) begin
        @(posedge hclk);
        c++;
      end
      chk(dma_req, 1'b1);
      pm = (pm & ~(m & (16'hF << 4 * g))) | (d & m & (16'hF << 4 * g));
      chk(pattern_out, pm);
      @(posedge hclk);
      chk(dma_req, 1'b0);
      repeat (2) @(posedge hclk);
      chk(irq, g > 0);
      xfer(1'b1, 32'h10, 32'h0);
      xfer(1'b0, 32'h1C, 32'h0);
      chk(rdv, {16'h0, pm});
    end
    xfer(1'b0, 32'h14, 32'h0);
    chk(rdv & 32'h1E0, 32'h1E0);
    xfer(1'b0, 32'h14, 32'h0);
    chk(rdv & 32'h1E0, 32'h0);
    chk(irq, 1'b0);
    xfer(1'b1, cha(1, TPPO_SUB_DUTY), 32'h2);
    d = ~pm;
    mid = pm & 16'hFF0F;
    xfer(1'b1, 32'h04, {16'h0, d});
    xfer(1'b1, 32'h08, 32'h00F0);
    xfer(1'b1, 32'h0C, 32'hFCF);
    xfer(1'b1, 32'h10, 32'h22);
    if (mid !== pm) wait_chg(pm);
    chk(pattern_out, mid);
    pm = mid | (d & 16'h00F0);
    if (pm !== mid) wait_chg(mid);
    chk(pattern_out, pm);
    xfer(1'b1, 32'h10, 32'h0);
    xfer(1'b1, cha(2, TPPO_SUB_PERIOD), 32'hFFFF);
    xfer(1'b1, 32'h00, 32'h3F);
    xfer(1'b0, cha(2, TPPO_SUB_CNT), 32'h0);
    c = int'(rdv);
    for (int i = 0; i < 8; i++) begin
      eb = enc_b;
      u_enc.gap = (i < 6) ? 4 : 12;
      u_enc.step(i < 6);
      #1;
      c = c + ((enc_a ^ eb) ? 1 : -1);
    end
    repeat (8) @(posedge hclk);
    xfer(1'b0, cha(2, TPPO_SUB_CNT), 32'h0);
    chk(rdv, 32'(c) & 32'hFFFF);
    xfer(1'b1, 32'h00, 32'h5F);
    for (int k = 0; k < 2; k++) begin
      xfer(1'b1, cha(3, TPPO_SUB_PERIOD), 32'd20);
      xfer(1'b1, cha(3, TPPO_SUB_DUTY), 32'(3 + 6 * k));
      repeat (50) @(posedge hclk);
      hi = 0;
      repeat (200) begin
        @(posedge hclk);
        hi += int'(wave_out[3]);
      end
      // A 0..20..0 triangle lasts 40 cycles and is below duty d for 2*d-1 of them.
      chk(hi, 5 * (12 * k + 5));
    end
    tally_and_finish();
  end
endmodule
`default_nettype wire

/* core/tppo_top.sv */
`timescale 1ns/100ps
`default_nettype none
module tppo_top
  import tppo_pkg::*;
(
  input wire logic hclk, // Bus and timer clock.
  input wire logic hresetn, // Asynchronous reset, active low.
  input wire logic ce, // Clock enable; low freezes all state.
  input wire logic hsel, // Slave select.
  input wire logic [31:0] haddr, // Byte address.
  input wire logic [1:0] htrans, // Transfer type.
  input wire logic hwrite, // Write when high.
  input wire logic [2:0] hsize, // Transfer size, word only.
  input wire logic [31:0] hwdata, // Write data.
  input wire logic hready, // Bus ready.
  output logic hreadyout, // Slave ready.
  output logic hresp, // Always OKAY.
  output logic [31:0] hrdata, // Read data.
  input wire logic enc_a, // Quadrature phase A pin.
  input wire logic enc_b, // Quadrature phase B pin.
  output logic [4:0] wave_out, // Per-channel PWM waveform.
  output logic [15:0] pattern_out, // Pattern output latches.
  output logic dma_req, // One-cycle pulse on a group update.
  output logic irq // Level interrupt.
);
  logic [6:0] ctrl_r, ctrl_nxt;
  logic [15:0] ndata_r, ndata_nxt;
  logic [15:0] nmask_r, nmask_nxt;
  logic [11:0] gsel_r, gsel_nxt;
  logic [7:0] gen_r, gen_nxt;
  logic [8:0] ist_r, ist_nxt;
  logic [8:0] imsk_r, imsk_nxt;
  logic [15:0] per_r [TPPO_NCH];
  logic [15:0] per_nxt [TPPO_NCH];
  logic [15:0] duty_r [TPPO_NCH];
  logic [15:0] duty_nxt [TPPO_NCH];
  logic [31:0] rdata_r, rdata_nxt;
  logic [7:0] waddr_r, waddr_nxt;
  logic wen_r, wen_nxt;
  logic [15:0] cnt_r [TPPO_NCH];
  logic [15:0] cnt_nxt [TPPO_NCH];
  logic updn_r, updn_nxt;
  logic [4:0] cma_r, cma_nxt, cmb_r, cmb_nxt;
  logic [4:0] wave_r;
  logic [4:0] wave_nxt;
  logic [1:0] qa_r, qb_r;
  logic qa_p_r, qb_p_r;
  logic [15:0] pout_r, pout_nxt;
  tppo_nov_t nov_r [TPPO_NGRP];
  tppo_nov_t nov_nxt [TPPO_NGRP];
  logic dma_r, dma_nxt;
  logic [3:0] gupd;
  logic addr_ok;
  logic rd_clr;
  logic [31:0] rd_val;
  logic [7:0] aoff;
  logic [2:0] chi;
  logic [3:0] sub;
  logic qstep, qup;
  // First byte address past the last channel; offsets beyond it must not alias onto a channel.
  localparam logic [7:0] TPPO_OFS_END = TPPO_OFS_CH0 + 8'(TPPO_NCH) * TPPO_CH_STRIDE;

  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = rdata_r;
  assign wave_out = wave_r;
  assign pattern_out = pout_r;
  assign dma_req = dma_r;
  assign irq = |(ist_r & imsk_r);

  assign addr_ok = hsel & hready & (htrans == TPPO_HTRANS_NONSEQ);
  assign aoff = haddr[7:0];
  assign chi = 3'((aoff - TPPO_OFS_CH0) >> 4);
  assign sub = aoff[3:0];

  // Read multiplexer, evaluated in the address phase.
  always_comb begin
    rd_val = 32'h0000_0000;
    case (aoff)
      TPPO_OFS_CTRL: rd_val = {25'h0, ctrl_r};
      TPPO_OFS_NXTDATA: rd_val = {16'h0, ndata_r};
      TPPO_OFS_NXTMASK: rd_val = {16'h0, nmask_r};
      TPPO_OFS_GRPSEL: rd_val = {20'h0, gsel_r};
      TPPO_OFS_GRPEN: rd_val = {24'h0, gen_r};
      TPPO_OFS_ISTAT: rd_val = {23'h0, ist_r};
      TPPO_OFS_IMASK: rd_val = {23'h0, imsk_r};
      TPPO_OFS_POUT: rd_val = {16'h0, pout_r};
      default: begin
        if (aoff >= TPPO_OFS_CH0 && aoff < TPPO_OFS_END) begin
          case (sub)
            TPPO_SUB_CNT: rd_val = {16'h0, cnt_r[chi]};
            TPPO_SUB_PERIOD: rd_val = {16'h0, per_r[chi]};
            TPPO_SUB_DUTY: rd_val = {16'h0, duty_r[chi]};
            default: rd_val = 32'h0000_0000;
          endcase
        end
      end
    endcase
  end

  assign rd_clr = ce & addr_ok & ~hwrite & (aoff == TPPO_OFS_ISTAT);

  // Bus and register group.
  always_comb begin
    logic [2:0] wc;
    wc = 3'((waddr_r - TPPO_OFS_CH0) >> 4);
    ctrl_nxt = ctrl_r;
    ndata_nxt = ndata_r;
    nmask_nxt = nmask_r;
    gsel_nxt = gsel_r;
    gen_nxt = gen_r;
    imsk_nxt = imsk_r;
    per_nxt = per_r;
    duty_nxt = duty_r;
    rdata_nxt = rdata_r;
    wen_nxt = wen_r;
    waddr_nxt = waddr_r;
    if (ce) begin
      wen_nxt = addr_ok & hwrite;
      waddr_nxt = aoff;
      if (addr_ok & ~hwrite) begin
        rdata_nxt = rd_val;
      end
      if (wen_r) begin
        case (waddr_r)
          TPPO_OFS_CTRL: ctrl_nxt = hwdata[6:0];
          TPPO_OFS_NXTDATA: ndata_nxt = hwdata[15:0];
          TPPO_OFS_NXTMASK: nmask_nxt = hwdata[15:0];
          TPPO_OFS_GRPSEL: gsel_nxt = hwdata[11:0];
          TPPO_OFS_GRPEN: gen_nxt = hwdata[7:0];
          TPPO_OFS_IMASK: imsk_nxt = hwdata[8:0];
          default: begin
            if (waddr_r >= TPPO_OFS_CH0 && waddr_r < TPPO_OFS_END) begin
              if (waddr_r[3:0] == TPPO_SUB_PERIOD) per_nxt[wc] = hwdata[15:0];
              if (waddr_r[3:0] == TPPO_SUB_DUTY) duty_nxt[wc] = hwdata[15:0];
            end
          end
        endcase
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl_r <= TPPO_RST_CTRL;
      ndata_r <= 16'h0000;
      nmask_r <= 16'h0000;
      gsel_r <= TPPO_RST_GRPSEL;
      gen_r <= TPPO_RST_GRPEN;
      imsk_r <= 9'h000;
      rdata_r <= 32'h0000_0000;
      wen_r <= 1'b0;
      waddr_r <= 8'h00;
      for (int i = 0; i < TPPO_NCH; i++) begin
        per_r[i] <= TPPO_RST_PERIOD;
        duty_r[i] <= TPPO_RST_DUTY;
      end
    end else begin
      ctrl_r <= ctrl_nxt;
      ndata_r <= ndata_nxt;
      nmask_r <= nmask_nxt;
      gsel_r <= gsel_nxt;
      gen_r <= gen_nxt;
      imsk_r <= imsk_nxt;
      rdata_r <= rdata_nxt;
      wen_r <= wen_nxt;
      waddr_r <= waddr_nxt;
      per_r <= per_nxt;
      duty_r <= duty_nxt;
    end
  end

  // Quadrature decode: one step per edge of either phase; the third stage feeds the edge check.
  assign qstep = (qa_r[1] ^ qa_p_r) | (qb_r[1] ^ qb_p_r);
  assign qup = qa_r[1] ^ qb_p_r;

  // Counter group.
  always_comb begin
    logic step;
    step = 1'b0;
    cnt_nxt = cnt_r;
    updn_nxt = updn_r;
    cma_nxt = cma_r;
    cmb_nxt = cmb_r;
    wave_nxt = wave_r;
    if (ce) begin
      for (int i = 0; i < TPPO_NCH; i++) begin
        step = ctrl_r[i];
        if (i == 2 && ctrl_r[TPPO_CTRL_PHASE]) begin
          step = ctrl_r[i] & qstep;
          if (step) cnt_nxt[i] = qup ? cnt_r[i] + 16'h0001 : cnt_r[i] - 16'h0001;
        end else if (i >= 3 && ctrl_r[TPPO_CTRL_PWM]) begin
          if (step) cnt_nxt[i] = updn_r ? cnt_r[i] + 16'h0001 : cnt_r[i] - 16'h0001;
        end else if (step) begin
          cnt_nxt[i] = (cnt_r[i] == per_r[i]) ? 16'h0000 : cnt_r[i] + 16'h0001;
        end
        cma_nxt[i] = step & (cnt_nxt[i] == per_r[i]);
        cmb_nxt[i] = step & (cnt_nxt[i] == duty_r[i]);
        wave_nxt[i] = cnt_nxt[i] < duty_r[i];
      end
      // Channel three leads the shared direction; four follows it.
      if (ctrl_r[TPPO_CTRL_PWM] && ctrl_r[3]) begin
        if (updn_r && cnt_nxt[3] >= per_r[3]) updn_nxt = 1'b0;
        else if (!updn_r && cnt_nxt[3] == 16'h0000) updn_nxt = 1'b1;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      for (int i = 0; i < TPPO_NCH; i++) cnt_r[i] <= TPPO_RST_CNT;
      updn_r <= 1'b1;
      cma_r <= 5'h00;
      cmb_r <= 5'h00;
      wave_r <= 5'h00;
      qa_r <= 2'b00;
      qb_r <= 2'b00;
      qa_p_r <= 1'b0;
      qb_p_r <= 1'b0;
    end else begin
      cnt_r <= cnt_nxt;
      updn_r <= updn_nxt;
      cma_r <= cma_nxt;
      cmb_r <= cmb_nxt;
      wave_r <= wave_nxt;
      if (ce) begin
        qa_r <= {qa_r[0], enc_a};
        qb_r <= {qb_r[0], enc_b};
        qa_p_r <= qa_r[1];
        qb_p_r <= qb_r[1];
      end
    end
  end

  // Pattern group.
  always_comb begin
    logic [2:0] sc;
    logic [3:0] msk, dat, cur;
    sc = 3'h0;
    msk = 4'h0;
    dat = 4'h0;
    cur = 4'h0;
    pout_nxt = pout_r;
    nov_nxt = nov_r;
    gupd = 4'h0;
    ist_nxt = rd_clr ? 9'h000 : ist_r;
    dma_nxt = dma_r;
    for (int g = 0; g < TPPO_NGRP; g++) begin
      sc = gsel_r[g*3 +: 3];
      msk = nmask_r[g*4 +: 4];
      dat = ndata_r[g*4 +: 4];
      cur = pout_r[g*4 +: 4];
      if (ce && gen_r[g] && sc < 3'(TPPO_NCH)) begin
        if (!gen_r[4+g]) begin
          if (cma_r[sc]) begin
            pout_nxt[g*4 +: 4] = (cur & ~msk) | (dat & msk);
            gupd[g] = 1'b1;
          end
        end else begin
          case (nov_r[g])
            TPPO_NOV_IDLE: begin
              if (cmb_r[sc]) begin
                pout_nxt[g*4 +: 4] = cur & ~(msk & ~dat);
                nov_nxt[g] = TPPO_NOV_CLEARED;
              end
            end
            TPPO_NOV_CLEARED: begin
              if (cma_r[sc]) begin
                pout_nxt[g*4 +: 4] = cur | (msk & dat);
                nov_nxt[g] = TPPO_NOV_IDLE;
                gupd[g] = 1'b1;
              end
            end
            default: nov_nxt[g] = TPPO_NOV_IDLE;
          endcase
        end
      end else if (ce && !gen_r[g]) begin
        nov_nxt[g] = TPPO_NOV_IDLE;
      end
    end
    if (ce) begin
      dma_nxt = |gupd;
      ist_nxt = ist_nxt | {gupd, cma_r};
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pout_r <= 16'h0000;
      for (int g = 0; g < TPPO_NGRP; g++) nov_r[g] <= TPPO_NOV_IDLE;
      ist_r <= 9'h000;
      dma_r <= 1'b0;
    end else begin
      pout_r <= pout_nxt;
      nov_r <= nov_nxt;
      ist_r <= ist_nxt;
      dma_r <= dma_nxt;
    end
  end
endmodule
`default_nettype wire

/* pkg/tppo_pkg.sv */
package tppo_pkg;
  localparam int unsigned TPPO_NCH = 5;
  localparam int unsigned TPPO_CW = 16;
  localparam int unsigned TPPO_NGRP = 4;
  localparam int unsigned TPPO_NEV = 9;
  localparam logic [7:0] TPPO_OFS_CTRL = 8'h00;
  localparam logic [7:0] TPPO_OFS_NXTDATA = 8'h04;
  localparam logic [7:0] TPPO_OFS_NXTMASK = 8'h08;
  localparam logic [7:0] TPPO_OFS_GRPSEL = 8'h0C;
  localparam logic [7:0] TPPO_OFS_GRPEN = 8'h10;
  localparam logic [7:0] TPPO_OFS_ISTAT = 8'h14;
  localparam logic [7:0] TPPO_OFS_IMASK = 8'h18;
  localparam logic [7:0] TPPO_OFS_POUT = 8'h1C;
  localparam logic [7:0] TPPO_OFS_CH0 = 8'h20;
  localparam logic [7:0] TPPO_CH_STRIDE = 8'h10;
  localparam logic [3:0] TPPO_SUB_CNT = 4'h0;
  localparam logic [3:0] TPPO_SUB_PERIOD = 4'h4;
  localparam logic [3:0] TPPO_SUB_DUTY = 4'h8;
  localparam int unsigned TPPO_CTRL_PHASE = 5;
  localparam int unsigned TPPO_CTRL_PWM = 6;
  localparam logic [6:0] TPPO_RST_CTRL = 7'h00;
  localparam logic [15:0] TPPO_RST_CNT = 16'h0000;
  localparam logic [15:0] TPPO_RST_PERIOD = 16'hFFFF;
  localparam logic [15:0] TPPO_RST_DUTY = 16'h0000;
  localparam logic [11:0] TPPO_RST_GRPSEL = 12'h000;
  localparam logic [7:0] TPPO_RST_GRPEN = 8'h00;
  localparam logic [1:0] TPPO_HTRANS_NONSEQ = 2'b10;
  typedef enum logic [1:0] {
    TPPO_NOV_IDLE = 2'b00,
    TPPO_NOV_CLEARED = 2'b01
  } tppo_nov_t;
endpackage
